//--- pkg/mspc_map.vh
// register map, field positions, reset values and timing counts of the
// metering scan and pulse configuration bank; definitions only.
`ifndef MSPC_MAP_VH
`define MSPC_MAP_VH

// byte offsets (16-bit words; 32-bit registers take two words, low first)
`define MSPC_SCAN_SLOT0_CFG 12'h010
`define MSPC_SCAN_SLOT7_CFG 12'h01e
`define MSPC_FRAME_TIME_CAL 12'h020
`define MSPC_VOLTAGE_SCALE 12'h022
`define MSPC_CURRENT_SCALE 12'h024
`define MSPC_POWER_SCALE 12'h026
`define MSPC_ENERGY_STEP_THRESHOLD 12'h028
`define MSPC_CHARGE_STEP_THRESHOLD 12'h02c
`define MSPC_CYCLES_PER_ENERGY 12'h030
`define MSPC_PULSE_OUTPUT_CFG 12'h032
`define MSPC_PULSE1_THRESHOLD 12'h034
`define MSPC_PULSE2_THRESHOLD 12'h038
`define MSPC_PULSE1_WIDTH 12'h03c
`define MSPC_PULSE2_WIDTH 12'h03e
`define MSPC_ALLPASS_COEF_FIRST 12'h054
`define MSPC_ALLPASS_COEF_SECOND 12'h056
`define MSPC_ZERO_CROSS_LOWPASS_COEF 12'h058
`define MSPC_CONVERSION_SPACING 12'h084

// word indices inside the bank
`define MSPC_IDX_SLOT0 5'd0
`define MSPC_IDX_FRAME 5'd8
`define MSPC_IDX_VSCALE 5'd9
`define MSPC_IDX_ISCALE 5'd10
`define MSPC_IDX_PSCALE 5'd11
`define MSPC_IDX_ESTEP 5'd12
`define MSPC_IDX_CSTEP 5'd14
`define MSPC_IDX_CYCLES 5'd16
`define MSPC_IDX_PULSE_OUTPUT_CFG 5'd17
`define MSPC_IDX_PULSE1_THRESHOLD 5'd18
`define MSPC_IDX_PULSE2_THRESHOLD 5'd20
`define MSPC_IDX_WID1 5'd22
`define MSPC_IDX_WID2 5'd23
`define MSPC_IDX_AP0 5'd24
`define MSPC_IDX_AP1 5'd25
`define MSPC_IDX_ZC 5'd26
`define MSPC_IDX_SPACING 5'd27
`define MSPC_NUM_WORDS 28

// reset values
`define MSPC_RST_SLOT0 16'h0301
`define MSPC_RST_SLOT1 16'h0003
`define MSPC_RST_SLOT2 16'h0505
`define MSPC_RST_SLOT3 16'h0207
`define MSPC_RST_SLOT4 16'h0409
`define MSPC_RST_SLOT5 16'h010b
`define MSPC_RST_SLOT6 16'h068d
`define MSPC_RST_SLOT7 16'h08af
`define MSPC_RST_FRAME 16'h07d0
`define MSPC_RST_VSCALE 16'h81f0
`define MSPC_RST_ISCALE 16'h17d8
`define MSPC_RST_PSCALE 16'h3539
`define MSPC_RST_ESTEP 32'h00841c2f
`define MSPC_RST_CSTEP 32'h11940000
`define MSPC_RST_CYCLES 16'h0001
`define MSPC_RST_PULSE_OUTPUT_CFG 16'h1707
`define MSPC_RST_THR 32'h019cd813
`define MSPC_RST_WIDTH 16'h186a
`define MSPC_RST_AP0 16'h3000
`define MSPC_RST_AP1 16'h5000
`define MSPC_RST_ZC 16'h1000
`define MSPC_RST_SPACING 16'h00c7

// field positions
`define MSPC_SLOT_CONN_MSB 3
`define MSPC_SLOT_CONN_LSB 1
`define MSPC_SLOT_SKIP_BIT 7
`define MSPC_SPACING_MSB 8
`define MSPC_P2_SRC_MSB 15
`define MSPC_P2_SRC_LSB 11
`define MSPC_P2_TERM_MSB 10
`define MSPC_P2_TERM_LSB 8
`define MSPC_P1_SRC_MSB 7
`define MSPC_P1_SRC_LSB 3
`define MSPC_P1_TERM_MSB 2
`define MSPC_P1_TERM_LSB 0
`define MSPC_CMD_WRITE_BIT 15

// scaling shifts
`define MSPC_VI_SHIFT 16
`define MSPC_PWR_SHIFT 26

// timing: one threshold count is 64 clocks, one width count is 8 us
`define MSPC_THR_CLOCKS_LOG2 6
`define MSPC_CLK_PERIOD_NS 8
`define MSPC_WIDTH_UNIT_NS 8000
`define MSPC_WIDTH_UNIT_CYCLES (`MSPC_WIDTH_UNIT_NS / `MSPC_CLK_PERIOD_NS)

`endif

//--- hw/mspc_top.v
// metering scan and pulse configuration bank with spi register port,
// scan sequencer, scaling, energy cycle counter and two pulse outputs.
// assumes a spi master in mode 0, sclk well below clk_i / 4.
//
// Function
// - slot bits 3:1 pick input IA,VA,IC,VC,IB,VB, neutral at 110.
// - frame time register holds scan frame duration in 0.1 us units.
// - reported voltage is voltage scale times rms voltage over 2^16.
// - reported current is current scale times rms current over 2^16.
// - reported power is power scale times current times voltage over 2^26.
// - 32-bit energy threshold sets energy accumulator step, default 0.0001 kWh.
// - 32-bit charge threshold sets amp-hour step, default 0.0001 kAh.
// - accumulate cycles_per_energy line cycles before each energy calculation.
// - pulse config bits 15:11 pick the second pulse source.
// - pulse config bits 10:8 enable each phase term for second pulse.
// - pulse config bits 7:3 pick the first pulse source.
// - pulse config bits 2:0 enable each phase term for first pulse.
// - first pulse threshold is 32 bits, one count is 64 clocks.
// - second pulse threshold is 32 bits, one count is 64 clocks.
// - first pulse width down-counter loads width register, default 50 ms.
// - second pulse width down-counter loads its register, default 50 ms.
// - slot bit 7 set skips that slot's conversion.
// - nine-bit conversion spacing is clocks between conversions minus one.
`include "mspc_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mspc_top #(
    parameter WIDTH_UNIT = `MSPC_WIDTH_UNIT_CYCLES
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire spi_sclk_i,
    input wire spi_ss_n_i,
    input wire spi_mosi_i,
    output reg spi_miso_o,
    output reg spi_miso_oe_o,
    output reg conv_start_o,
    output reg [2:0] conv_slot_o,
    output reg [2:0] conv_input_o,
    output reg [3:0] conv_mux_o,
    output reg [2:0] conv_gain_o,
    input wire [15:0] vrms_i,
    input wire [15:0] irms_i,
    output reg [15:0] volt_rep_o,
    output reg [15:0] curr_rep_o,
    output reg [21:0] pwr_rep_o,
    input wire line_cycle_i,
    output reg energy_calc_o,
    output reg [31:0] energy_step_o,
    output reg [31:0] charge_step_o,
    output reg [15:0] frame_time_o,
    output reg [4:0] first_pulse_source_o,
    output reg [4:0] second_pulse_source_o,
    input wire energy_valid_i,
    input wire [15:0] phase_e1_i,
    input wire [15:0] phase_e2_i,
    input wire [15:0] phase_e3_i,
    output reg pulse1_o,
    output reg pulse2_o
);

    // 32-bit defaults kept whole so each half is cut on purpose
    localparam [31:0] ESTEP_RST = `MSPC_RST_ESTEP;
    localparam [31:0] CSTEP_RST = `MSPC_RST_CSTEP;
    localparam [31:0] THR_RST = `MSPC_RST_THR;

    function [4:0] word_index;
        input [11:0] addr;
        begin
            if (addr >= `MSPC_SCAN_SLOT0_CFG && addr <= `MSPC_PULSE2_WIDTH)
                word_index = addr[5:1] - 5'd8;
            else if (addr == `MSPC_ALLPASS_COEF_FIRST)
                word_index = `MSPC_IDX_AP0;
            else if (addr == `MSPC_ALLPASS_COEF_SECOND)
                word_index = `MSPC_IDX_AP1;
            else if (addr == `MSPC_ZERO_CROSS_LOWPASS_COEF)
                word_index = `MSPC_IDX_ZC;
            else if (addr == `MSPC_CONVERSION_SPACING)
                word_index = `MSPC_IDX_SPACING;
            else
                word_index = 5'h1f;
        end
    endfunction

    function [15:0] reset_word;
        input [4:0] idx;
        begin
            case (idx)
                5'd0: reset_word = `MSPC_RST_SLOT0;
                5'd1: reset_word = `MSPC_RST_SLOT1;
                5'd2: reset_word = `MSPC_RST_SLOT2;
                5'd3: reset_word = `MSPC_RST_SLOT3;
                5'd4: reset_word = `MSPC_RST_SLOT4;
                5'd5: reset_word = `MSPC_RST_SLOT5;
                5'd6: reset_word = `MSPC_RST_SLOT6;
                5'd7: reset_word = `MSPC_RST_SLOT7;
                `MSPC_IDX_FRAME: reset_word = `MSPC_RST_FRAME;
                `MSPC_IDX_VSCALE: reset_word = `MSPC_RST_VSCALE;
                `MSPC_IDX_ISCALE: reset_word = `MSPC_RST_ISCALE;
                `MSPC_IDX_PSCALE: reset_word = `MSPC_RST_PSCALE;
                5'd12: reset_word = ESTEP_RST[15:0];
                5'd13: reset_word = ESTEP_RST[31:16];
                5'd14: reset_word = CSTEP_RST[15:0];
                5'd15: reset_word = CSTEP_RST[31:16];
                `MSPC_IDX_CYCLES: reset_word = `MSPC_RST_CYCLES;
                `MSPC_IDX_PULSE_OUTPUT_CFG: reset_word = `MSPC_RST_PULSE_OUTPUT_CFG;
                5'd18, 5'd20: reset_word = THR_RST[15:0];
                5'd19, 5'd21: reset_word = THR_RST[31:16];
                5'd22, 5'd23: reset_word = `MSPC_RST_WIDTH;
                `MSPC_IDX_AP0: reset_word = `MSPC_RST_AP0;
                `MSPC_IDX_AP1: reset_word = `MSPC_RST_AP1;
                `MSPC_IDX_ZC: reset_word = `MSPC_RST_ZC;
                `MSPC_IDX_SPACING: reset_word = `MSPC_RST_SPACING;
                default: reset_word = 16'h0000;
            endcase
        end
    endfunction

    reg [15:0] regs_q [0:`MSPC_NUM_WORDS-1];
    integer i;

    // pin synchronisers: stage 1 feeds stage 2 only
    // sclk gets a third stage for its edge detector
    reg [2:0] sclk_q;
    reg [1:0] ss_q, mosi_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 3'h0;
            ss_q <= 2'h3;
            mosi_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], spi_sclk_i};
            ss_q <= {ss_q[0], spi_ss_n_i};
            mosi_q <= {mosi_q[0], spi_mosi_i};
        end
    end
    wire sel = ~ss_q[1];
    wire sclk_rise = sel & sclk_q[1] & ~sclk_q[2];
    wire sclk_fall = sel & ~sclk_q[1] & sclk_q[2];

    // frame: 16-bit command (bit 15 write, 11:0 byte address), 16-bit data
    reg [5:0] bit_cnt_q;
    reg [15:0] shin_q, shout_q, cmd_q;
    wire [4:0] cmd_idx = word_index(cmd_q[11:0]);
    wire [15:0] rx_word = {shin_q[14:0], mosi_q[1]};
    wire [4:0] new_idx = word_index(rx_word[11:0]);
    wire do_write = sclk_rise && bit_cnt_q == 6'd31 && cmd_q[`MSPC_CMD_WRITE_BIT]
                    && cmd_idx != 5'h1f;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt_q <= 6'h00;
            shin_q <= 16'h0000;
            shout_q <= 16'h0000;
            cmd_q <= 16'h0000;
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else begin
            spi_miso_oe_o <= sel;
            if (!sel) begin
                bit_cnt_q <= 6'h00;
                spi_miso_o <= 1'b0;
            end else if (sclk_rise) begin
                shin_q <= rx_word;
                bit_cnt_q <= (bit_cnt_q == 6'd31) ? 6'h00 : bit_cnt_q + 6'd1;
                if (bit_cnt_q == 6'd15) begin
                    cmd_q <= rx_word;
                    // unmapped addresses read as zero
                    shout_q <= (new_idx == 5'h1f) ? 16'h0000 : regs_q[new_idx];
                end
            end else if (sclk_fall && bit_cnt_q >= 6'd16) begin
                spi_miso_o <= shout_q[15];
                shout_q <= {shout_q[14:0], 1'b0};
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (i = 0; i < `MSPC_NUM_WORDS; i = i + 1)
                regs_q[i] <= reset_word(i[4:0]);
        end else if (do_write) begin
            regs_q[cmd_idx] <= rx_word;
        end
    end

    wire [15:0] pulse_output_cfg = regs_q[`MSPC_IDX_PULSE_OUTPUT_CFG];
    wire [8:0] spacing = regs_q[`MSPC_IDX_SPACING][`MSPC_SPACING_MSB:0];

    // scan sequencer: one conversion slot every spacing+1 clocks
    reg [8:0] gap_q;
    reg [2:0] slot_q;
    wire [15:0] cur_slot = regs_q[slot_q];
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_q <= 9'h000;
            slot_q <= 3'h0;
            conv_start_o <= 1'b0;
            conv_slot_o <= 3'h0;
            conv_input_o <= 3'h0;
            conv_mux_o <= 4'h0;
            conv_gain_o <= 3'h0;
        end else begin
            conv_start_o <= 1'b0;
            if (gap_q >= spacing) begin
                gap_q <= 9'h000;
                slot_q <= slot_q + 3'd1;
                conv_start_o <= ~cur_slot[`MSPC_SLOT_SKIP_BIT];
                conv_slot_o <= slot_q;
                conv_input_o <= cur_slot[`MSPC_SLOT_CONN_MSB:`MSPC_SLOT_CONN_LSB];
                conv_mux_o <= cur_slot[11:8];
                conv_gain_o <= cur_slot[6:4];
            end else begin
                gap_q <= gap_q + 9'd1;
            end
        end
    end

    // scaling of measured rms values
    wire [31:0] v_prod = regs_q[`MSPC_IDX_VSCALE] * vrms_i;
    wire [31:0] i_prod = regs_q[`MSPC_IDX_ISCALE] * irms_i;
    wire [47:0] p_prod = regs_q[`MSPC_IDX_PSCALE] * irms_i * vrms_i;

    // line cycle counter for energy calculation
    reg [15:0] cyc_q;
    wire [15:0] cyc_next = cyc_q + 16'd1;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc_q <= 16'h0000;
            energy_calc_o <= 1'b0;
            volt_rep_o <= 16'h0000;
            curr_rep_o <= 16'h0000;
            pwr_rep_o <= 22'h000000;
            energy_step_o <= 32'h00000000;
            charge_step_o <= 32'h00000000;
            frame_time_o <= 16'h0000;
            first_pulse_source_o <= 5'h00;
            second_pulse_source_o <= 5'h00;
        end else begin
            volt_rep_o <= v_prod[31:`MSPC_VI_SHIFT];
            curr_rep_o <= i_prod[31:`MSPC_VI_SHIFT];
            pwr_rep_o <= p_prod[47:`MSPC_PWR_SHIFT];
            energy_step_o <= {regs_q[`MSPC_IDX_ESTEP+1], regs_q[`MSPC_IDX_ESTEP]};
            charge_step_o <= {regs_q[`MSPC_IDX_CSTEP+1], regs_q[`MSPC_IDX_CSTEP]};
            frame_time_o <= regs_q[`MSPC_IDX_FRAME];
            first_pulse_source_o <= pulse_output_cfg[`MSPC_P1_SRC_MSB:`MSPC_P1_SRC_LSB];
            second_pulse_source_o <= pulse_output_cfg[`MSPC_P2_SRC_MSB:`MSPC_P2_SRC_LSB];
            energy_calc_o <= 1'b0;
            if (line_cycle_i) begin
                // a count of zero behaves as one
                if (cyc_next >= regs_q[`MSPC_IDX_CYCLES]) begin
                    cyc_q <= 16'h0000;
                    energy_calc_o <= 1'b1;
                end else begin
                    cyc_q <= cyc_next;
                end
            end
        end
    end

    // pulse channels: accumulate selected terms, fire at threshold * 64
    wire [2:0] term1 = pulse_output_cfg[`MSPC_P1_TERM_MSB:`MSPC_P1_TERM_LSB];
    wire [2:0] term2 = pulse_output_cfg[`MSPC_P2_TERM_MSB:`MSPC_P2_TERM_LSB];
    wire [17:0] inc1 = (term1[0] ? {2'b00, phase_e1_i} : 18'h0)
                     + (term1[1] ? {2'b00, phase_e2_i} : 18'h0)
                     + (term1[2] ? {2'b00, phase_e3_i} : 18'h0);
    wire [17:0] inc2 = (term2[0] ? {2'b00, phase_e1_i} : 18'h0)
                     + (term2[1] ? {2'b00, phase_e2_i} : 18'h0)
                     + (term2[2] ? {2'b00, phase_e3_i} : 18'h0);
    wire [37:0] lim1 = {regs_q[`MSPC_IDX_PULSE1_THRESHOLD+1], regs_q[`MSPC_IDX_PULSE1_THRESHOLD], 6'h00};
    wire [37:0] lim2 = {regs_q[`MSPC_IDX_PULSE2_THRESHOLD+1], regs_q[`MSPC_IDX_PULSE2_THRESHOLD], 6'h00};
    reg [38:0] acc1_q, acc2_q;
    wire [38:0] sum1 = acc1_q + {21'h0, energy_valid_i ? inc1 : 18'h0};
    wire [38:0] sum2 = acc2_q + {21'h0, energy_valid_i ? inc2 : 18'h0};
    wire hit1 = sum1 >= {1'b0, lim1};
    wire hit2 = sum2 >= {1'b0, lim2};

    // width timers tick every 8 us so 16 bits cover 50 ms and more
    reg [15:0] tick_q;
    reg [15:0] wid1_q, wid2_q;
    wire tick = tick_q == WIDTH_UNIT - 1;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_q <= 16'h0000;
            acc1_q <= 39'h0;
            acc2_q <= 39'h0;
            wid1_q <= 16'h0000;
            wid2_q <= 16'h0000;
            pulse1_o <= 1'b0;
            pulse2_o <= 1'b0;
        end else begin
            tick_q <= tick ? 16'h0000 : tick_q + 16'd1;
            acc1_q <= hit1 ? sum1 - {1'b0, lim1} : sum1;
            acc2_q <= hit2 ? sum2 - {1'b0, lim2} : sum2;
            // a threshold hit while a pulse runs restarts its width
            if (hit1)
                wid1_q <= regs_q[`MSPC_IDX_WID1];
            else if (tick && wid1_q != 16'h0000)
                wid1_q <= wid1_q - 16'd1;
            if (hit2)
                wid2_q <= regs_q[`MSPC_IDX_WID2];
            else if (tick && wid2_q != 16'h0000)
                wid2_q <= wid2_q - 16'd1;
            pulse1_o <= hit1 ? (regs_q[`MSPC_IDX_WID1] != 16'h0000) : (wid1_q != 16'h0000);
            pulse2_o <= hit2 ? (regs_q[`MSPC_IDX_WID2] != 16'h0000) : (wid2_q != 16'h0000);
        end
    end

endmodule // mspc_top

`default_nettype wire

//--- verif/mspc_top_properties.sv
// checker for the scan and pulse configuration bank, watching ports only.
// assumes one clock domain and a host that keeps to the spi framing.
`timescale 1ns/1ps
`default_nettype none
module mspc_chk #(
    parameter int WIDTH_UNIT = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_ss_n_i,
    input wire logic spi_miso_oe_o,
    input wire logic conv_start_o,
    input wire logic [2:0] conv_slot_o,
    input wire logic line_cycle_i,
    input wire logic energy_calc_o,
    input wire logic [31:0] energy_step_o,
    input wire logic energy_valid_i,
    input wire logic pulse1_o,
    input wire logic pulse2_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    oe_on_a: assert property (!spi_ss_n_i [*6] |-> spi_miso_oe_o)
        else $error("miso enable low while selected");
    oe_off_a: assert property (spi_ss_n_i [*6] |-> !spi_miso_oe_o)
        else $error("miso enable high while idle");
    calc_cause_a: assert property (energy_calc_o |-> $past(line_cycle_i) || $past(line_cycle_i, 2))
        else $error("energy calc without line cycle");
    pulse_cause_a: assert property ($rose(pulse1_o) |-> $past(energy_valid_i) ||
        $past(energy_valid_i, 2) || $past(energy_valid_i, 3))
        else $error("pulse1 rose without energy update");
    pulse1_min_a: assert property ($rose(pulse1_o) |-> pulse1_o [*3])
        else $error("pulse1 too short");
    pulse2_min_a: assert property ($rose(pulse2_o) |-> pulse2_o [*3])
        else $error("pulse2 too short");
    slot_order_a: assert property ($changed(conv_slot_o) |-> conv_slot_o == $past(conv_slot_o) + 3'd1)
        else $error("scan slot out of order");
    step_hold_a: assert property (spi_ss_n_i [*8] |-> $stable(energy_step_o))
        else $error("energy step changed without host access");
    cover property ($rose(pulse1_o));
    cover property (energy_calc_o);
    cover property (conv_start_o && conv_slot_o == 3'd5);
endmodule // mspc_chk
bind mspc_top mspc_chk #(.WIDTH_UNIT(WIDTH_UNIT)) i_mspc_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .spi_ss_n_i(spi_ss_n_i), .spi_miso_oe_o(spi_miso_oe_o), .conv_start_o(conv_start_o),
    .conv_slot_o(conv_slot_o), .line_cycle_i(line_cycle_i), .energy_calc_o(energy_calc_o),
    .energy_step_o(energy_step_o), .energy_valid_i(energy_valid_i), .pulse1_o(pulse1_o),
    .pulse2_o(pulse2_o));
`default_nettype wire

//--- verif/mspc_host.sv
// host model: spi master in mode 0 on the register port.
// assumes clk_i is the device clock; sclk stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module mspc_host (
    input wire logic clk_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic sclk_o,
    output logic ss_n_o,
    output logic mosi_o
);
    logic last_q = 1'b0;
    // released miso shows the inverse of its last level, never a stale copy
    wire logic miso_w = miso_oe_i ? miso_i : ~last_q;
    always @(posedge clk_i) last_q <= miso_w;
    initial begin
        sclk_o = 1'b0;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // half period of 6 clocks stays above the 4-clock minimum
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] wd,
                        output logic [15:0] rd);
        logic [31:0] f;
        f = {w, 3'h0, a, wd};
        rd = 16'h0000;
        ss_n_o <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi_o <= f[i];
            repeat (6) @(posedge clk_i);
            if (i < 16) rd[i] = miso_w;
            sclk_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        ss_n_o <= 1'b1;
        mosi_o <= ~f[0];
        repeat (6) @(posedge clk_i);
    endtask
endmodule // mspc_host
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the scan and pulse configuration bank.
// assumes the host model and the bound checker beside mspc_top.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, rst_n_i = 1'b0, line_cycle_i = 1'b0, energy_valid_i = 1'b0;
    logic [15:0] vrms_i = 16'h1234, irms_i = 16'habcd, e1 = 16'h0, e2 = 16'h0, e3 = 16'h0;
    wire sclk, ss_n, mosi, miso, miso_oe, cst, p1, p2, ecalc;
    wire [2:0] slot, cin, gain;
    wire [3:0] mux;
    wire [15:0] vrep, crep, ftime;
    wire [21:0] prep;
    wire [31:0] estep, cstep;
    wire [4:0] src1, src2;
    int failures = 0, compares = 0, cycles = 0, calcs = 0, steps = 0, n;
    logic [15:0] rd;
    logic [2:0] prev = 3'd0;
    logic [7:0] seen = 8'h00;
    logic [11:0] adr [4] = '{12'h054, 12'h056, 12'h058, 12'h084};
    logic [15:0] dflt [28] = '{16'h0301, 16'h0003, 16'h0505, 16'h0207, 16'h0409, 16'h010b,
        16'h068d, 16'h08af, 16'h07d0, 16'h81f0, 16'h17d8, 16'h3539, 16'h1c2f, 16'h0084,
        16'h0000, 16'h1194, 16'h0001, 16'h1707, 16'hd813, 16'h019c, 16'hd813, 16'h019c,
        16'h186a, 16'h186a, 16'h3000, 16'h5000, 16'h1000, 16'h00c7};
    // slot 7 is left alone; slot 2 gets its skip bit
    logic [27:0] tbl [10] = '{{12'h084, 16'h0009}, {12'h014, 16'h0585}, {12'h030, 16'h0003},
        {12'h032, 16'h1209}, {12'h034, 16'h0001}, {12'h036, 16'h0000}, {12'h038, 16'h0001},
        {12'h03a, 16'h0000}, {12'h03c, 16'h0003}, {12'h03e, 16'h0002}};
    always #4 clk_i = ~clk_i;
    mspc_top #(.WIDTH_UNIT(4)) i_mspc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .spi_sclk_i(sclk), .spi_ss_n_i(ss_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .conv_start_o(cst), .conv_slot_o(slot),
        .conv_input_o(cin), .conv_mux_o(mux), .conv_gain_o(gain), .vrms_i(vrms_i),
        .irms_i(irms_i), .volt_rep_o(vrep), .curr_rep_o(crep), .pwr_rep_o(prep),
        .line_cycle_i(line_cycle_i), .energy_calc_o(ecalc), .energy_step_o(estep),
        .charge_step_o(cstep), .frame_time_o(ftime), .first_pulse_source_o(src1),
        .second_pulse_source_o(src2), .energy_valid_i(energy_valid_i), .phase_e1_i(e1),
        .phase_e2_i(e2), .phase_e3_i(e3), .pulse1_o(p1), .pulse2_o(p2));
    mspc_host i_mspc_host (.clk_i(clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
        .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi));
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        i_mspc_host.xfer(1'b1, a, v, rd);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
        i_mspc_host.xfer(1'b0, a, 16'h0000, rd);
        check("register", {16'h0, rd}, {16'h0, exp});
    endtask
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        calcs <= calcs + int'(ecalc === 1'b1);
        prev <= slot;
        if (slot !== prev) steps <= steps + 1;
        if (cst === 1'b1) seen[slot] <= 1'b1;
        if (cst === 1'b1) check("slot input", {22'h0, mux, gain, cin},
            {22'h0, dflt[slot][11:8], dflt[slot][6:4], dflt[slot][3:1]});
        if (cycles == 50000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("volt", {16'h0, vrep}, 32'((32'h81f0 * vrms_i) >> 16));
        check("curr", {16'h0, crep}, 32'((32'h17d8 * irms_i) >> 16));
        check("pwr", {10'h0, prep}, 32'((48'h3539 * irms_i * vrms_i) >> 26));
        for (int k = 0; k < 28; k++) rchk(k < 24 ? 12'h010 + 12'(2 * k) : adr[k - 24], dflt[k]);
        wr(12'h040, 16'hffff);
        rchk(12'h040, 16'h0000);
        $display("test defaults done");
        for (int k = 0; k < 19; k++) wr(k < 16 ? 12'h020 + 12'(2 * k) : adr[k - 16], 16'ha000 + 16'(k));
        for (int k = 0; k < 19; k++) rchk(k < 16 ? 12'h020 + 12'(2 * k) : adr[k - 16], 16'ha000 + 16'(k));
        check("frame", {16'h0, ftime}, 32'h0000a000);
        check("estep", estep, 32'ha005a004);
        check("cstep", cstep, 32'ha007a006);
        check("src2", {27'h0, src2}, 32'h14);
        check("src1", {27'h0, src1}, 32'h01);
        $display("test readback done");
        for (int k = 0; k < 10; k++) wr(tbl[k][27:16], tbl[k][15:0]);
        repeat (250) @(posedge clk_i);
        n = steps;
        seen <= 8'h00;
        repeat (100) @(posedge clk_i);
        check("steps", steps - n, 10);
        // slots 2, 6 and 7 carry the skip bit
        check("started", {24'h0, seen}, 32'h3b);
        $display("test scan done");
        n = calcs;
        repeat (7) begin
            line_cycle_i <= 1'b1;
            @(posedge clk_i);
            line_cycle_i <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        check("calcs", calcs - n, 2);
        $display("test cycles done");
        e1 <= 16'd32;
        e2 <= 16'd64;
        e3 <= 16'd999;
        energy_valid_i <= 1'b1;
        @(posedge clk_i);
        energy_valid_i <= 1'b0;
        e2 <= 16'd0;
        repeat (5) @(posedge clk_i);
        check("pulse2", {31'h0, p2}, 32'h1);
        check("pulse1", {31'h0, p1}, 32'h0);
        repeat (20) @(posedge clk_i);
        energy_valid_i <= 1'b1;
        @(posedge clk_i);
        energy_valid_i <= 1'b0;
        n = 0;
        repeat (40) begin
            @(posedge clk_i);
            n += int'(p1 === 1'b1);
        end
        check("width1", 32'(n >= 11 && n <= 13), 32'h1);
        $display("test pulses done");
        conclude();
    end
endmodule // testbench
`default_nettype wire
